// ---- rtl/core_memory_pkg.sv ----
// How it works
// - pointer top bits pick one of four banks
// - indirect: location from pointer low six bits
// - direct: location from opcode, bank from pointer
// - indirect port redirects to pointed register
// - page-one registers answer the same in every bank
// - page-one registers sit at fixed addresses
// - storage bytes at 0x10..0x2F of bank zero
// - second/third pages only via dedicated instructions
// - bank bits ignored for second/third pages
// - second and third page register decode
// - timer reads live count, write replaces it
// - timer clocked by three selectable sources
// - counter low byte increments, resets to zero
// - top counter bit from high buffer on low writes and short calls
// - jumps load all nine counter bits
// - short call: low byte, buffer bit, push
// - long call loads nine bits and pushes
// - status bit layout and reset values
// - sleep flag: set power-up/clear, cleared sleep
// - expiry flag: zero on timeout, else one
// - carry set on add carry or no borrow
package core_memory_pkg;
  localparam logic [5:0] ADDR_INDIRECT    = 6'h00;
  localparam logic [5:0] ADDR_TIMER       = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW      = 6'h02;
  localparam logic [5:0] ADDR_STATUS      = 6'h03;
  localparam logic [5:0] ADDR_POINTER     = 6'h04;
  localparam logic [5:0] ADDR_PORT_DATA   = 6'h06;
  localparam logic [5:0] ADDR_POWER_CTRL  = 6'h08;
  localparam logic [5:0] ADDR_WAKEUP_CTRL = 6'h09;
  localparam logic [5:0] ADDR_PC_HIGH_BUF = 6'h0A;
  localparam logic [5:0] ADDR_PULLDOWN    = 6'h0B;
  localparam logic [5:0] ADDR_PULLUP      = 6'h0C;
  localparam logic [5:0] ADDR_IRQ_ENABLE  = 6'h0E;
  localparam logic [5:0] ADDR_IRQ_FLAG    = 6'h0F;
  localparam logic [5:0] ADDR_SFR_LAST    = 6'h0F;
  localparam logic [5:0] ADDR_STORE_FIRST = 6'h10;
  localparam logic [5:0] ADDR_STORE_LAST  = 6'h2F;
  localparam logic [3:0] F_PORT_DIR       = 4'h6;
  localparam logic [3:0] F_PRESCALER      = 4'hA;
  localparam logic [3:0] F_BROWNOUT       = 4'hC;
  localparam logic [3:0] F_POWER2         = 4'hF;
  localparam logic [3:0] S_TIMEBASE_A     = 4'h7;
  localparam logic [3:0] S_TIMEBASE_B     = 4'h8;
  localparam logic [3:0] S_OSC_CTRL       = 4'hF;
  localparam int         BANK_HI          = 7;
  localparam int         BANK_LO          = 6;
  localparam int         ST_EXPIRY        = 4;
  localparam int         ST_SLEEP         = 3;
  localparam int         ST_ZERO          = 2;
  localparam int         ST_NIBBLE        = 1;
  localparam int         ST_CARRY         = 0;
  localparam logic [7:0] STATUS_RESET     = 8'h18;
  localparam logic [7:0] POINTER_RESET    = 8'h00;
  localparam logic [8:0] PC_RESET         = 9'h000;
  localparam logic [7:0] BYTE_ZERO        = 8'h00;
  localparam int         STORE_DEPTH      = 32;
endpackage

// ---- rtl/banked_data_memory_core_sfr.sv ----
`timescale 1ns/1ps
module banked_data_memory_core_sfr #(
  parameter int STORE_WORDS = core_memory_pkg::STORE_DEPTH
) (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [5:0] opcode_addr_i,
  input  wire logic       io_setup_write_instr_i,
  input  wire logic       io_setup_read_instr_i,
  input  wire logic       special_page_write_instr_i,
  input  wire logic       special_page_read_instr_i,
  input  wire logic [3:0] page_addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       step_i,
  input  wire logic       short_jump_instr_i,
  input  wire logic       long_jump_instr_i,
  input  wire logic       short_call_instr_i,
  input  wire logic       long_call_instr_i,
  input  wire logic [8:0] target_i,
  input  wire logic       flag_update_i,
  input  wire logic       carry_i,
  input  wire logic       nibble_overflow_bit_i,
  input  wire logic       zero_i,
  input  wire logic       sleep_instr_i,
  input  wire logic       clear_watchdog_instr_i,
  input  wire logic       watchdog_timeout_i,
  input  wire logic       timer_mode_bits_i,
  input  wire logic       cfg_ext_source_i,
  input  wire logic       external_timer_clock_pin_i,
  input  wire logic       low_osc_tick_i,
  output logic [7:0]      rdata_o,
  output logic            rdata_valid_o,
  output logic [8:0]      pc_o,
  output logic            push_o,
  output logic [8:0]      push_addr_o,
  output logic [7:0]      status_o,
  output logic [7:0]      timer_o
);

  typedef struct packed {
    logic [STORE_WORDS-1:0][7:0] store;
    logic [7:0]                  pointer;
    logic [7:0]                  timer;
    logic                        ext_prev;
    logic [8:0]                  pc;
    logic                        pc_high_buffer;
    logic [7:0]                  status;
    // page-one registers kept as plain storage
    logic [7:0]                  port_data;
    logic [7:0]                  power_ctrl;
    logic [7:0]                  wakeup_ctrl;
    logic [7:0]                  pulldown_ctrl;
    logic [7:0]                  pullup_ctrl;
    logic [7:0]                  irq_enable;
    logic [7:0]                  irq_flag;
    // second and third page registers
    logic [7:0]                  port_dir;
    logic [7:0]                  prescaler;
    logic [7:0]                  brownout;
    logic [7:0]                  power2;
    logic [7:0]                  timebase_a;
    logic [7:0]                  timebase_b;
    logic [7:0]                  osc_ctrl;
    // registered outputs
    logic [7:0]                  rdata;
    logic                        rdata_valid;
    logic                        push;
    logic [8:0]                  push_addr;
  } state_type;

  // current state and its next value
  state_type cur;
  state_type next_cur;

  // combinational address resolution for page-one accesses
  logic [1:0] bank_number;
  logic [5:0] location;
  logic       loc_is_store;
  logic [4:0] store_index;
  logic       timer_tick;
  logic       pc_written;
  logic       ext_rise;
  logic [8:0] pc_next_seq;

  always_comb begin
    // bank from the pointer, location from the opcode or the pointer
    bank_number = cur.pointer[core_memory_pkg::BANK_HI:core_memory_pkg::BANK_LO];
    location    = opcode_addr_i;
    if (opcode_addr_i == core_memory_pkg::ADDR_INDIRECT) begin
      location = cur.pointer[5:0];
    end
    // storage only answers in bank zero; other banks read as unused
    loc_is_store = (bank_number == 2'b00) &&
                   (location >= core_memory_pkg::ADDR_STORE_FIRST) &&
                   (location <= core_memory_pkg::ADDR_STORE_LAST);
    store_index  = 5'(location - core_memory_pkg::ADDR_STORE_FIRST);
    // pin edge judged against last cycle's pin level
    ext_rise     = external_timer_clock_pin_i && !cur.ext_prev;
    // timer source select: instruction clock, pin edge or slow oscillator
    if (!timer_mode_bits_i) begin
      timer_tick = step_i;
    end else if (cfg_ext_source_i) begin
      timer_tick = ext_rise;
    end else begin
      timer_tick = low_osc_tick_i;
    end
    // a counter low write reloads the counter like a jump
    pc_written  = wr_i && (location == core_memory_pkg::ADDR_PC_LOW);
    // following instruction address, also the value pushed by calls
    pc_next_seq = 9'(cur.pc + 9'h001);
  end

  // next state: register reads, writes, counter, timer and flags
  always_comb begin
    next_cur             = cur;
    next_cur.ext_prev    = external_timer_clock_pin_i;
    next_cur.rdata_valid = 1'b0;
    next_cur.push        = 1'b0;

    // timer runs freely; a write below replaces the count
    if (timer_tick) begin
      next_cur.timer = 8'(cur.timer + 8'h01);
    end

    // page-one read, same decode in every bank below 0x10
    if (rd_i) begin
      next_cur.rdata_valid = 1'b1;
      next_cur.rdata       = core_memory_pkg::BYTE_ZERO;
      // storage first, then registers below 0x10 in any bank
      if (loc_is_store) begin
        next_cur.rdata = cur.store[store_index];
      end else if (location == core_memory_pkg::ADDR_TIMER) begin
        next_cur.rdata = cur.timer;
      end else if (location == core_memory_pkg::ADDR_PC_LOW) begin
        next_cur.rdata = cur.pc[7:0];
      end else if (location == core_memory_pkg::ADDR_STATUS) begin
        next_cur.rdata = cur.status;
      end else if (location == core_memory_pkg::ADDR_POINTER) begin
        next_cur.rdata = cur.pointer;
      end else if (location == core_memory_pkg::ADDR_PORT_DATA) begin
        next_cur.rdata = cur.port_data;
      end else if (location == core_memory_pkg::ADDR_POWER_CTRL) begin
        next_cur.rdata = cur.power_ctrl;
      end else if (location == core_memory_pkg::ADDR_WAKEUP_CTRL) begin
        next_cur.rdata = cur.wakeup_ctrl;
      end else if (location == core_memory_pkg::ADDR_PC_HIGH_BUF) begin
        next_cur.rdata = {7'h00, cur.pc_high_buffer};
      end else if (location == core_memory_pkg::ADDR_PULLDOWN) begin
        next_cur.rdata = cur.pulldown_ctrl;
      end else if (location == core_memory_pkg::ADDR_PULLUP) begin
        next_cur.rdata = cur.pullup_ctrl;
      end else if (location == core_memory_pkg::ADDR_IRQ_ENABLE) begin
        next_cur.rdata = cur.irq_enable;
      end else if (location == core_memory_pkg::ADDR_IRQ_FLAG) begin
        next_cur.rdata = cur.irq_flag;
      end
    end

    // second and third page reads, bank bits not consulted
    if (io_setup_read_instr_i) begin
      next_cur.rdata_valid = 1'b1;
      next_cur.rdata       = core_memory_pkg::BYTE_ZERO;
      if (page_addr_i == core_memory_pkg::F_PORT_DIR) begin
        next_cur.rdata = cur.port_dir;
      end else if (page_addr_i == core_memory_pkg::F_PRESCALER) begin
        next_cur.rdata = cur.prescaler;
      end else if (page_addr_i == core_memory_pkg::F_BROWNOUT) begin
        next_cur.rdata = cur.brownout;
      end else if (page_addr_i == core_memory_pkg::F_POWER2) begin
        next_cur.rdata = cur.power2;
      end
    end else if (special_page_read_instr_i) begin
      next_cur.rdata_valid = 1'b1;
      next_cur.rdata       = core_memory_pkg::BYTE_ZERO;
      if (page_addr_i == core_memory_pkg::S_TIMEBASE_A) begin
        next_cur.rdata = cur.timebase_a;
      end else if (page_addr_i == core_memory_pkg::S_TIMEBASE_B) begin
        next_cur.rdata = cur.timebase_b;
      end else if (page_addr_i == core_memory_pkg::S_OSC_CTRL) begin
        next_cur.rdata = cur.osc_ctrl;
      end
    end

    // page-one write; unassigned and unused locations are dropped
    if (wr_i) begin
      // counter low byte writes are taken in the counter block below
      if (loc_is_store) begin
        next_cur.store[store_index] = wdata_i;
      end else if (location == core_memory_pkg::ADDR_TIMER) begin
        next_cur.timer = wdata_i;
      end else if (location == core_memory_pkg::ADDR_STATUS) begin
        next_cur.status = wdata_i;
      end else if (location == core_memory_pkg::ADDR_POINTER) begin
        next_cur.pointer = wdata_i;
      end else if (location == core_memory_pkg::ADDR_PORT_DATA) begin
        next_cur.port_data = wdata_i;
      end else if (location == core_memory_pkg::ADDR_POWER_CTRL) begin
        next_cur.power_ctrl = wdata_i;
      end else if (location == core_memory_pkg::ADDR_WAKEUP_CTRL) begin
        next_cur.wakeup_ctrl = wdata_i;
      end else if (location == core_memory_pkg::ADDR_PC_HIGH_BUF) begin
        next_cur.pc_high_buffer = wdata_i[0];
      end else if (location == core_memory_pkg::ADDR_PULLDOWN) begin
        next_cur.pulldown_ctrl = wdata_i;
      end else if (location == core_memory_pkg::ADDR_PULLUP) begin
        next_cur.pullup_ctrl = wdata_i;
      end else if (location == core_memory_pkg::ADDR_IRQ_ENABLE) begin
        next_cur.irq_enable = wdata_i;
      end else if (location == core_memory_pkg::ADDR_IRQ_FLAG) begin
        next_cur.irq_flag = wdata_i;
      end
    end

    // second and third page writes
    if (io_setup_write_instr_i) begin
      if (page_addr_i == core_memory_pkg::F_PORT_DIR) begin
        next_cur.port_dir = wdata_i;
      end else if (page_addr_i == core_memory_pkg::F_PRESCALER) begin
        next_cur.prescaler = wdata_i;
      end else if (page_addr_i == core_memory_pkg::F_BROWNOUT) begin
        next_cur.brownout = wdata_i;
      end else if (page_addr_i == core_memory_pkg::F_POWER2) begin
        next_cur.power2 = wdata_i;
      end
    end else if (special_page_write_instr_i) begin
      if (page_addr_i == core_memory_pkg::S_TIMEBASE_A) begin
        next_cur.timebase_a = wdata_i;
      end else if (page_addr_i == core_memory_pkg::S_TIMEBASE_B) begin
        next_cur.timebase_b = wdata_i;
      end else if (page_addr_i == core_memory_pkg::S_OSC_CTRL) begin
        next_cur.osc_ctrl = wdata_i;
      end
    end

    // arithmetic result flags override a software write
    if (flag_update_i) begin
      next_cur.status[core_memory_pkg::ST_CARRY]  = carry_i;
      next_cur.status[core_memory_pkg::ST_NIBBLE] = nibble_overflow_bit_i;
      next_cur.status[core_memory_pkg::ST_ZERO]   = zero_i;
    end
    // instruction and watchdog events override a software write
    if (clear_watchdog_instr_i) begin
      next_cur.status[core_memory_pkg::ST_SLEEP]  = 1'b1;
      next_cur.status[core_memory_pkg::ST_EXPIRY] = 1'b1;
    end
    // sleep outranks a same-cycle watchdog clear
    if (sleep_instr_i) begin
      next_cur.status[core_memory_pkg::ST_SLEEP]  = 1'b0;
      next_cur.status[core_memory_pkg::ST_EXPIRY] = 1'b1;
    end
    // timeout last, so it outranks sleep and clear
    if (watchdog_timeout_i) begin
      next_cur.status[core_memory_pkg::ST_EXPIRY] = 1'b0;
    end

    // program counter: loads take priority over the step
    if (short_jump_instr_i || long_jump_instr_i) begin
      next_cur.pc = target_i;
    end else if (short_call_instr_i) begin
      next_cur.pc        = {cur.pc_high_buffer, target_i[7:0]};
      next_cur.push      = 1'b1;
      next_cur.push_addr = pc_next_seq;
    end else if (long_call_instr_i) begin
      next_cur.pc        = target_i;
      next_cur.push      = 1'b1;
      next_cur.push_addr = pc_next_seq;
    end else if (pc_written) begin
      next_cur.pc = {cur.pc_high_buffer, wdata_i};
    end else if (step_i) begin
      next_cur.pc = pc_next_seq;
    end

    // synchronous reset values
    if (srst_i) begin
      // storage and all plain registers clear to zero
      next_cur             = '0;
      next_cur.pointer     = core_memory_pkg::POINTER_RESET;
      next_cur.pc          = core_memory_pkg::PC_RESET;
      next_cur.status      = core_memory_pkg::STATUS_RESET;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    // reset still acts while the clock enable is low
    if (ce_i || srst_i) begin
      cur <= next_cur;
    end
  end

  // outputs straight from state flops
  assign rdata_o       = cur.rdata;
  assign rdata_valid_o = cur.rdata_valid;
  assign pc_o          = cur.pc;
  assign push_o        = cur.push;
  assign push_addr_o   = cur.push_addr;
  assign status_o      = cur.status;
  assign timer_o       = cur.timer;

endmodule

// ---- bench/banked_data_memory_core_sfr_monitor.sv ----
`timescale 1ns/1ps
module banked_data_memory_core_sfr_monitor (
  input logic       clk_i,
  input logic       srst_i,
  input logic       ce_i,
  input logic       rd_i,
  input logic       wr_i,
  input logic       step_i,
  input logic       short_jump_instr_i,
  input logic       long_jump_instr_i,
  input logic       short_call_instr_i,
  input logic       long_call_instr_i,
  input logic [8:0] target_i,
  input logic       flag_update_i,
  input logic       carry_i,
  input logic       nibble_overflow_bit_i,
  input logic       zero_i,
  input logic       sleep_instr_i,
  input logic       watchdog_timeout_i,
  input logic       rdata_valid_o,
  input logic [8:0] pc_o,
  input logic       push_o,
  input logic [8:0] push_addr_o,
  input logic [7:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // jumps outrank calls, so calls are only judged without a jump
  wire jmp = short_jump_instr_i | long_jump_instr_i;
  sequence s_short_call;
    ce_i && short_call_instr_i && !jmp;
  endsequence
  sequence s_long_call;
    ce_i && long_call_instr_i && !jmp && !short_call_instr_i;
  endsequence
  a_read_answer: assert property (ce_i && rd_i |=> rdata_valid_o)
    else $error("read not answered next cycle");
  a_step_count: assert property (ce_i && step_i && !jmp && !short_call_instr_i
    && !long_call_instr_i && !wr_i |=> pc_o == $past(pc_o) + 9'h001)
    else $error("program counter did not advance by one");
  a_jump_load: assert property (ce_i && jmp |=> pc_o == $past(target_i) && !push_o)
    else $error("jump did not load target");
  a_short_call: assert property (s_short_call |=> push_o && pc_o[7:0] == $past(target_i[7:0])
    && push_addr_o == $past(pc_o) + 9'h001)
    else $error("short call load or push wrong");
  a_long_call: assert property (s_long_call |=> push_o && pc_o == $past(target_i)
    && push_addr_o == $past(pc_o) + 9'h001)
    else $error("long call load or push wrong");
  a_push_cause: assert property ($rose(push_o) |-> $past(ce_i && (short_call_instr_i
    || long_call_instr_i)))
    else $error("push without a call");
  a_sleep_flags: assert property (ce_i && sleep_instr_i && !watchdog_timeout_i
    |=> status_o[4:3] == 2'b10)
    else $error("sleep did not set flags");
  a_timeout_flag: assert property (ce_i && watchdog_timeout_i |=> !status_o[4])
    else $error("expiry flag not cleared on timeout");
  a_alu_flags: assert property (ce_i && flag_update_i
    |=> status_o[2:0] == $past({zero_i, nibble_overflow_bit_i, carry_i}))
    else $error("arithmetic flags not captured");
  a_hold_frozen: assert property (!ce_i |=> $stable(pc_o) && $stable(status_o))
    else $error("state moved while clock enable low");
endmodule
bind banked_data_memory_core_sfr banked_data_memory_core_sfr_monitor i_mon (
  .clk_i, .srst_i, .ce_i, .rd_i, .wr_i, .step_i, .short_jump_instr_i, .long_jump_instr_i,
  .short_call_instr_i, .long_call_instr_i, .target_i, .flag_update_i, .carry_i,
  .nibble_overflow_bit_i, .zero_i, .sleep_instr_i, .watchdog_timeout_i, .rdata_valid_o,
  .pc_o, .push_o, .push_addr_o, .status_o);

// ---- bench/banked_data_memory_core_sfr_tb.sv ----
`timescale 1ns/1ps
module banked_data_memory_core_sfr_tb;
  logic       clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, rd_i = 1'b0, wr_i = 1'b0;
  logic       step_i = 1'b0, flag_update_i = 1'b0, timer_mode_bits_i = 1'b0;
  logic       cfg_ext_source_i = 1'b0, external_timer_clock_pin_i = 1'b0, low_osc_tick_i = 1'b0;
  logic [3:0] pst = 4'h0, bst = 4'h0, page_addr_i = 4'h0;
  logic [2:0] est = 3'h0, alu = 3'h0;
  logic [5:0] opcode_addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00, rdata_o, status_o, timer_o, ptr, tmr, st, d;
  logic [8:0] target_i = 9'h000, pc_o, push_addr_o, pc;
  logic       rdata_valid_o, push_o;
  logic [7:0] m [64];
  logic [3:0] pa [7] = '{4'h6, 4'hA, 4'hC, 4'hF, 4'h7, 4'h8, 4'hF};
  int         bad_count = 0, n_compared = 0, cyc = 0, i, k;

  always #12.5 clk_i = ~clk_i;

  banked_data_memory_core_sfr i_dut (
    .clk_i, .srst_i, .ce_i, .rd_i, .wr_i, .opcode_addr_i,
    .io_setup_write_instr_i(pst[3]), .io_setup_read_instr_i(pst[2]),
    .special_page_write_instr_i(pst[1]), .special_page_read_instr_i(pst[0]),
    .page_addr_i, .wdata_i, .step_i, .short_jump_instr_i(bst[3]), .long_jump_instr_i(bst[2]),
    .short_call_instr_i(bst[1]), .long_call_instr_i(bst[0]), .target_i, .flag_update_i,
    .carry_i(alu[0]), .nibble_overflow_bit_i(alu[1]), .zero_i(alu[2]),
    .sleep_instr_i(est[2]), .clear_watchdog_instr_i(est[1]), .watchdog_timeout_i(est[0]),
    .timer_mode_bits_i, .cfg_ext_source_i, .external_timer_clock_pin_i, .low_osc_tick_i,
    .rdata_o, .rdata_valid_o, .pc_o, .push_o, .push_addr_o, .status_o, .timer_o);

  // cut a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      summarize;
    end
  end

  task automatic tick;
    @(posedge clk_i);
    #2;
  endtask

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // model: value a page-one read should return
  function automatic logic [7:0] ev(input logic [5:0] a);
    logic [5:0] l;
    l = (a == 6'h00) ? ptr[5:0] : a;
    if (l == 6'h00 || l == 6'h05 || l == 6'h07 || l == 6'h0D) return 8'h00;
    if (l == 6'h01) return tmr;
    if (l == 6'h02) return pc[7:0];
    if (l == 6'h03) return st;
    if (l == 6'h04) return ptr;
    if (l < 6'h10 || (ptr[7:6] == 2'b00 && l <= 6'h2F)) return m[l];
    return 8'h00;
  endfunction

  task automatic w(input logic [5:0] a, input logic [7:0] v);
    logic [5:0] l;
    l = (a == 6'h00) ? ptr[5:0] : a;
    opcode_addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    tick;
    wr_i = 1'b0;
    tick;
    case (l)
      6'h01: tmr = v;
      6'h02: pc = {m[10][0], v};
      6'h03: st = v;
      6'h04: ptr = v;
      6'h0A: m[10] = {7'h00, v[0]};
      6'h00, 6'h05, 6'h07, 6'h0D: ;
      default: if (l < 6'h10 || (ptr[7:6] == 2'b00 && l <= 6'h2F)) m[l] = v;
    endcase
  endtask

  task automatic rd(input logic [5:0] a);
    logic [7:0] e;
    e = ev(a);
    opcode_addr_i = a;
    rd_i = 1'b1;
    tick;
    rd_i = 1'b0;
    chk({1'b0, rdata_o}, {1'b0, e});
    chk({8'h00, rdata_valid_o}, 9'h001);
    tick;
  endtask

  task automatic pg(input logic [3:0] s, input logic [3:0] a, input logic [7:0] v,
                    input logic [7:0] e);
    pst = s;
    page_addr_i = a;
    wdata_i = v;
    tick;
    pst = 4'h0;
    if (s[2] | s[0]) chk({1'b0, rdata_o}, {1'b0, e});
    tick;
  endtask

  task automatic br(input logic [3:0] s, input logic [8:0] a);
    bst = s;
    target_i = a;
    tick;
    bst = 4'h0;
    if (s[1] | s[0]) chk(push_addr_o, pc + 9'h001);
    chk({8'h00, push_o}, {8'h00, s[1] | s[0]});
    pc = s[1] ? {m[10][0], a[7:0]} : a;
    chk(pc_o, pc);
    tick;
  endtask

  task automatic evt(input logic [2:0] s);
    est = s;
    tick;
    est = 3'h0;
    if (s[2]) st[4:3] = 2'b10;
    if (s[1]) st[4:3] = 2'b11;
    if (s[0]) st[4] = 1'b0;
    chk({1'b0, status_o}, {1'b0, st});
    tick;
  endtask

  task automatic pulse_timer(input int n, input logic ext);
    repeat (n) begin
      if (ext) external_timer_clock_pin_i = 1'b1;
      else low_osc_tick_i = 1'b1;
      tick;
      external_timer_clock_pin_i = 1'b0;
      low_osc_tick_i = 1'b0;
      tick;
    end
    repeat (2) tick;
    tmr = tmr + 8'(n);
    chk({1'b0, timer_o}, {1'b0, tmr});
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    k = $urandom(32'h112a);
    for (i = 0; i < 64; i++) m[i] = 8'h00;
    ptr = 8'h00;
    tmr = 8'h00;
    st = 8'h18;
    pc = 9'h000;
    repeat (6) tick;
    srst_i = 1'b0;
    chk({1'b0, status_o}, 9'h018);
    chk(pc_o, 9'h000);
    $display("test reset done");
    for (i = 16; i < 48; i++) w(i[5:0], 8'($urandom));
    for (i = 16; i < 48; i++) rd(i[5:0]);
    w(6'h05, 8'hFF);
    rd(6'h05);
    w(6'h04, 8'h15);
    rd(6'h00);
    w(6'h00, 8'h5A);
    rd(6'h15);
    w(6'h04, 8'hD5);
    rd(6'h00);
    rd(6'h03);
    w(6'h08, 8'h3C);
    rd(6'h1F);
    w(6'h04, 8'h00);
    rd(6'h08);
    rd(6'h1F);
    $display("test memory done");
    w(6'h04, 8'hC0);
    for (i = 0; i < 7; i++) begin
      k = (i < 4) ? 8 : 2;
      d = 8'($urandom);
      pg(k[3:0], pa[i], d, 8'h00);
      pg(k[3:0] >> 1, pa[i], 8'h00, d);
    end
    pg(4'b0100, 4'h0, 8'h00, 8'h00);
    pg(4'b0001, 4'h6, 8'h00, 8'h00);
    $display("test pages done");
    w(6'h01, 8'hFB);
    step_i = 1'b1;
    repeat (6) tick;
    step_i = 1'b0;
    pc = pc + 9'h006;
    tmr = tmr + 8'h06;
    pulse_timer(0, 1'b0);
    chk(pc_o, pc);
    ce_i = 1'b0;
    step_i = 1'b1;
    repeat (3) tick;
    chk(pc_o, pc);
    chk({1'b0, timer_o}, {1'b0, tmr});
    ce_i = 1'b1;
    step_i = 1'b0;
    rd(6'h01);
    timer_mode_bits_i = 1'b1;
    cfg_ext_source_i = 1'b1;
    pulse_timer(3, 1'b1);
    cfg_ext_source_i = 1'b0;
    pulse_timer(4, 1'b0);
    $display("test timer done");
    for (i = 0; i < 12; i++) begin
      w(6'h0A, 8'($urandom));
      rd(6'h0A);
      br(4'b1000 >> (i % 4), 9'($urandom));
      w(6'h02, 8'($urandom));
      chk(pc_o, pc);
    end
    $display("test branch done");
    flag_update_i = 1'b1;
    for (i = 0; i < 8; i++) begin
      alu = i[2:0];
      tick;
      st[2:0] = i[2:0];
      chk({1'b0, status_o}, {1'b0, st});
    end
    flag_update_i = 1'b0;
    evt(3'b001);
    evt(3'b010);
    evt(3'b100);
    evt(3'b001);
    w(6'h03, 8'hE7);
    rd(6'h03);
    srst_i = 1'b1;
    tick;
    srst_i = 1'b0;
    chk({1'b0, status_o}, 9'h018);
    chk(pc_o, 9'h000);
    $display("test status done");
    summarize;
  end
endmodule
